// *** rpm_pkg.sv ***
// Package of constants for the reduced power mode control block.
package rpm_pkg;
   // Register offsets and field positions.
   localparam logic [7:0] PMC_ADDR       = 8'h87;
   localparam int         IDLE_BIT       = 0;
   localparam int         PDOWN_BIT      = 1;
   localparam int         FLAG_LOW_BIT   = 2;
   localparam int         FLAG_HIGH_BIT  = 3;
   localparam logic [7:0] PMC_RESET      = 8'h00;
   localparam logic [7:0] PMC_WR_MASK    = 8'h0F;
   localparam logic [7:0] STATUS_ADDR    = 8'h88;
   // Timing counts in oscillator periods.
   localparam int         OSC_PER_MC     = 12;
   localparam int         RESET_MIN_OSC  = 24;
   localparam int         WAKE_DELAY_OSC = 1536;
   localparam logic [3:0] MC_LAST        = 4'hB;
   localparam logic [4:0] RST_QUAL_LAST  = 5'h17;
   localparam logic [10:0] WAKE_LAST     = 11'h5FF;

   typedef enum logic [1:0] {
      RPM_RUN   = 2'b00,
      RPM_IDLE  = 2'b01,
      RPM_PDOWN = 2'b10,
      RPM_WAKE  = 2'b11
   } rpm_state_t;
endpackage

// *** rpm_ctrl.sv ***
// Reduced power mode control: idle and power-down entry, exit and wake delay.
`timescale 1ns/1ps
`default_nettype none
// The clock keeps running through power-down in this block; the stopped
// oscillator shows only in the clock enables, the held divider and the
// wake delay count. Reset and wake timing are counted on this one clock,
// in oscillator periods.
module rpm_ctrl (
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_clk_en,
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   input  wire logic       i_ext_reset,
   input  wire logic       i_irq_pending,
   input  wire logic [7:0] i_wake_interrupt_inputs,
   input  wire logic [7:0] i_wake_enable,
   input  wire logic       i_instr_done,
   input  wire logic       i_ale_run,
   input  wire logic       i_program_fetch_strobe_run,
   output logic            o_cpu_clk_en,
   output logic            o_periph_clk_en,
   output logic            o_osc_en,
   output logic            o_mc_tick,
   output logic            o_sfr_reset,
   output logic            o_ale,
   output logic            o_program_fetch_strobe,
   output logic            o_port_hold
);
   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   logic       rst_s1_r, rst_s2_r;
   logic [7:0] wk_s1_r, wk_s2_r;
   // The reset pin rests low and the wake pins rest high, so neither
   // synchroniser shows a false event when reset is released.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else if (i_clk_en) begin
         rst_s1_r <= i_ext_reset;
         rst_s2_r <= rst_s1_r;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wk_s1_r <= 8'hFF;
         wk_s2_r <= 8'hFF;
      end else if (i_clk_en) begin
         wk_s1_r <= i_wake_interrupt_inputs;
         wk_s2_r <= wk_s1_r;
      end
   end

   // ****************************************************************
   // State registers
   // ****************************************************************
   // All state below freezes while the clock enable is low.
   rpm_pkg::rpm_state_t state_r, state_nxt;
   logic [7:0]  pmc_r, pmc_nxt;
   logic [3:0]  mc_r, mc_nxt;
   logic [4:0]  rq_r, rq_nxt;
   logic [10:0] wd_r, wd_nxt;
   logic        sfr_rst_r, sfr_rst_nxt;
   logic        pend_r, pend_nxt;
   logic [7:0]  rdata_r, rdata_nxt;

   function automatic logic cnt_last4(input logic [3:0] c);
      return c == rpm_pkg::MC_LAST;
   endfunction

   // Shared address decode for the write and read paths.
   function automatic logic addr_is(input logic [7:0] a, input logic [7:0] reg_addr);
      return a == reg_addr;
   endfunction

   logic wr_pmc, wake_hit, rst_qual, wake_done;
   always_comb begin
      wr_pmc    = i_wr && addr_is(i_addr, rpm_pkg::PMC_ADDR);
      // Wake interrupt inputs are active low.
      wake_hit  = |(~wk_s2_r & i_wake_enable);
      rst_qual  = rst_s2_r && (rq_r == rpm_pkg::RST_QUAL_LAST);
      // The wake delay ends once the count reaches its last value.
      wake_done = wd_r == rpm_pkg::WAKE_LAST;
   end

   // ****************************************************************
   // Machine cycle divider
   // ****************************************************************
   // The divider halts with the oscillator and resumes where it stopped.
   always_comb begin
      mc_nxt = mc_r;
      if (state_r != rpm_pkg::RPM_PDOWN) begin
         mc_nxt = cnt_last4(mc_r) ? 4'h0 : mc_r + 4'h1;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mc_r <= 4'h0;
      end else if (i_clk_en) begin
         mc_r <= mc_nxt;
      end
   end

   // ****************************************************************
   // Reset qualification
   // ****************************************************************
   // A reset shorter than two machine cycles is ignored; one that stays
   // high keeps the registers cleared every cycle.
   always_comb begin
      rq_nxt      = rq_r;
      sfr_rst_nxt = rst_qual;
      if (!rst_s2_r) begin
         rq_nxt = 5'h00;
      end else if (rq_r != rpm_pkg::RST_QUAL_LAST) begin
         rq_nxt = rq_r + 5'h01;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rq_r      <= 5'h00;
         sfr_rst_r <= 1'b1;
      end else if (i_clk_en) begin
         rq_r      <= rq_nxt;
         sfr_rst_r <= sfr_rst_nxt;
      end
   end

   // ****************************************************************
   // Register readback
   // ****************************************************************
   // Read data stand for one cycle and are zero otherwise, so an unmapped
   // address reads as zero.
   always_comb begin
      rdata_nxt = 8'h00;
      if (i_rd) begin
         if (addr_is(i_addr, rpm_pkg::PMC_ADDR)) begin
            rdata_nxt = pmc_r;
         end else if (addr_is(i_addr, rpm_pkg::STATUS_ADDR)) begin
            rdata_nxt = {6'h00, state_r};
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_r <= 8'h00;
      end else if (i_clk_en) begin
         rdata_r <= rdata_nxt;
      end
   end

   // ****************************************************************
   // Wake delay counter
   // ****************************************************************
   // The count restarts in every power-down, so each wake waits in full.
   always_comb begin
      wd_nxt = wd_r;
      if (state_r == rpm_pkg::RPM_PDOWN) begin
         wd_nxt = 11'h000;
      end else if (state_r == rpm_pkg::RPM_WAKE && !wake_done) begin
         wd_nxt = wd_r + 11'h001;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wd_r <= 11'h000;
      end else if (i_clk_en) begin
         wd_r <= wd_nxt;
      end
   end

   // ****************************************************************
   // Mode control
   // ****************************************************************
   // Entry is held pending until the writing instruction completes.
   always_comb begin
      state_nxt = state_r;
      pmc_nxt   = pmc_r;
      pend_nxt  = pend_r;
      if (wr_pmc) begin
         pmc_nxt = i_wdata & rpm_pkg::PMC_WR_MASK;
         pend_nxt = i_wdata[rpm_pkg::IDLE_BIT] | i_wdata[rpm_pkg::PDOWN_BIT];
      end
      case (state_r)
         rpm_pkg::RPM_RUN: begin
            // Entry waits for the writing instruction to complete.
            if (pend_r && i_instr_done) begin
               // A write taken in the same cycle arms a new request.
               if (!wr_pmc) begin
                  pend_nxt = 1'b0;
               end
               // Power-down wins when both request bits are set.
               if (pmc_r[rpm_pkg::PDOWN_BIT]) begin
                  state_nxt = rpm_pkg::RPM_PDOWN;
               end else if (pmc_r[rpm_pkg::IDLE_BIT]) begin
                  state_nxt = rpm_pkg::RPM_IDLE;
               end
            end
         end
         rpm_pkg::RPM_IDLE: begin
            // The hardware clear of the idle bit beats a same-cycle write.
            if (i_irq_pending) begin
               pmc_nxt[rpm_pkg::IDLE_BIT] = 1'b0;
               state_nxt = rpm_pkg::RPM_RUN;
            end
         end
         rpm_pkg::RPM_PDOWN: begin
            if (wake_hit) begin
               state_nxt = rpm_pkg::RPM_WAKE;
            end
         end
         rpm_pkg::RPM_WAKE: begin
            if (wake_done) begin
               pmc_nxt[rpm_pkg::PDOWN_BIT] = 1'b0;
               state_nxt = rpm_pkg::RPM_RUN;
            end
         end
         default: state_nxt = rpm_pkg::RPM_RUN;
      endcase
      // Qualified reset restores registers and returns to run.
      if (rst_qual) begin
         state_nxt   = rpm_pkg::RPM_RUN;
         pmc_nxt     = rpm_pkg::PMC_RESET;
         pend_nxt    = 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= rpm_pkg::RPM_RUN;
         pmc_r   <= rpm_pkg::PMC_RESET;
         pend_r  <= 1'b0;
      end else if (i_clk_en) begin
         state_r <= state_nxt;
         pmc_r   <= pmc_nxt;
         pend_r  <= pend_nxt;
      end
   end

   // ****************************************************************
   // Clock gates and pin control
   // ****************************************************************
   logic in_run, in_idle, osc_off;
   always_comb begin
      in_run  = state_r == rpm_pkg::RPM_RUN;
      in_idle = state_r == rpm_pkg::RPM_IDLE;
      osc_off = state_r == rpm_pkg::RPM_PDOWN;
   end

   // The CPU clock is gated off in idle, power-down and the wake delay.
   assign o_cpu_clk_en    = in_run;
   assign o_periph_clk_en = in_run | in_idle;
   assign o_osc_en        = !osc_off;
   // The tick is masked while the clock enable freezes the divider, so a
   // frozen count never reads as a run of ticks.
   assign o_mc_tick       = cnt_last4(mc_r) && !osc_off && i_clk_en;
   assign o_sfr_reset     = sfr_rst_r;
   assign o_rdata         = rdata_r;
   always_comb begin
      // Idle parks the strobes high; power-down and the wake delay low.
      if (in_idle) begin
         o_ale                  = 1'b1;
         o_program_fetch_strobe = 1'b1;
      end else if (in_run) begin
         o_ale                  = i_ale_run;
         o_program_fetch_strobe = i_program_fetch_strobe_run;
      end else begin
         o_ale                  = 1'b0;
         o_program_fetch_strobe = 1'b0;
      end
   end
   assign o_port_hold = !in_run;
endmodule
`default_nettype wire

// *** rpm_ctrl_sva.sv ***
// Assertion checker for the reduced power mode control block.
`timescale 1ns/1ps
`default_nettype none
module rpm_ctrl_sva (
   input wire logic       i_ref_clk,
   input wire logic       i_rst_n,
   input wire logic       i_clk_en,
   input wire logic       i_rd,
   input wire logic       i_instr_done,
   input wire logic       i_irq_pending,
   input wire logic [7:0] o_rdata,
   input wire logic       o_cpu_clk_en,
   input wire logic       o_periph_clk_en,
   input wire logic       o_osc_en,
   input wire logic       o_mc_tick,
   input wire logic       o_sfr_reset,
   input wire logic       o_ale,
   input wire logic       o_program_fetch_strobe,
   input wire logic       o_port_hold
);
   logic        wake;
   logic [11:0] wcnt_r;
   logic [11:0] wcnt_nxt;
   assign wake = o_osc_en && !o_cpu_clk_en && !o_periph_clk_en;
   always_comb wcnt_nxt = wake ? wcnt_r + 12'h001 : 12'h000;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) wcnt_r <= 12'h000;
      else wcnt_r <= wcnt_nxt;
   end
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);
   sequence s_idle;
      !o_cpu_clk_en && o_periph_clk_en;
   endsequence
   property p_entry; $fell(o_cpu_clk_en) |-> $past(i_instr_done); endproperty
   a_entry: assert property (p_entry) else $error("cpu clock stopped early");
   property p_run; o_cpu_clk_en |-> o_periph_clk_en && o_osc_en; endproperty
   a_run: assert property (p_run) else $error("clock enables wrong in run");
   property p_idle; s_idle |-> o_ale && o_program_fetch_strobe && o_port_hold; endproperty
   a_idle: assert property (p_idle) else $error("idle pins wrong");
   property p_pd;
      !o_osc_en |-> !o_ale && !o_program_fetch_strobe && o_port_hold && !o_mc_tick;
   endproperty
   a_pd: assert property (p_pd) else $error("power-down pins wrong");
   property p_irq; s_idle ##0 (i_irq_pending && i_clk_en) |=> o_cpu_clk_en; endproperty
   a_irq: assert property (p_irq) else $error("interrupt did not end idle");
   property p_tick; o_mc_tick |=> !o_mc_tick [*8]; endproperty
   a_tick: assert property (p_tick) else $error("machine cycle too short");
   property p_rdz; !(i_rd && i_clk_en) |=> o_rdata == 8'h00; endproperty
   a_rdz: assert property (p_rdz) else $error("read data outside slot");
   property p_wake; $fell(wake) && !o_sfr_reset |-> wcnt_r == 12'h600; endproperty
   a_wake: assert property (p_wake) else $error("wake delay length wrong");
   property p_sfr; o_sfr_reset |-> o_cpu_clk_en; endproperty
   a_sfr: assert property (p_sfr) else $error("reset left a low power state");
endmodule
bind rpm_ctrl rpm_ctrl_sva u_sva (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
   .i_clk_en(i_clk_en), .i_rd(i_rd), .i_instr_done(i_instr_done), .o_rdata(o_rdata),
   .i_irq_pending(i_irq_pending), .o_cpu_clk_en(o_cpu_clk_en), .o_osc_en(o_osc_en),
   .o_periph_clk_en(o_periph_clk_en), .o_mc_tick(o_mc_tick), .o_sfr_reset(o_sfr_reset),
   .o_ale(o_ale), .o_program_fetch_strobe(o_program_fetch_strobe), .o_port_hold(o_port_hold));
`default_nettype wire

// *** rpm_cpu_model.sv ***
// CPU core and reset source model facing the power mode control block.
`timescale 1ns/1ps
`default_nettype none
module rpm_cpu_model (
   input  wire logic i_ref_clk,
   input  wire logic i_rst_n,
   input  wire logic i_cpu_clk_en,
   input  wire logic i_mc_tick,
   input  wire logic i_reset_req,
   output var logic  o_instr_done,
   output var logic  o_ale,
   output var logic  o_fetch,
   output logic      o_ext_reset
);
   logic [5:0] rcnt_r;
   // Reset is held 40 periods, past qualification, with the oscillator taken as stable.
   assign o_ext_reset = rcnt_r != 6'h00;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_instr_done <= 1'b0;
         o_ale <= 1'b0;
         o_fetch <= 1'b1;
         rcnt_r <= 6'h00;
      end else begin
         o_instr_done <= i_cpu_clk_en && i_mc_tick;
         o_ale <= i_cpu_clk_en ? !o_ale : 1'b0;
         o_fetch <= i_cpu_clk_en ? o_ale : 1'b1;
         rcnt_r <= i_reset_req ? 6'h28 : rcnt_r - {5'h00, o_ext_reset};
      end
   end
endmodule
`default_nettype wire

// *** test_reduced_power_mode_control.sv ***
// Self-checking testbench for the reduced power mode control block.
`timescale 1ns/1ps
`default_nettype none
module test_reduced_power_mode_control;
   logic       clk, done, ale, pfs, xrst, cpu, per, osc, tick, sfr, ale_o, pfs_o, hold;
   logic       rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, irq = 1'b0, rreq = 1'b0, rd_d = 1'b0;
   logic       ce = 1'b1;
   logic [7:0] addr = 8'h00, wd = 8'h00, wk_n = 8'hFF, wk_en = 8'h00, rdata, d, pin;
   logic [7:0] exp_q[$];
   int         n_fail = 0, tests_run = 0, cyc = 0;
   rpm_ctrl dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(ce), .i_addr(addr),
      .i_wdata(wd), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_ext_reset(xrst),
      .i_irq_pending(irq), .i_wake_interrupt_inputs(wk_n), .i_wake_enable(wk_en),
      .i_instr_done(done), .i_ale_run(ale), .i_program_fetch_strobe_run(pfs),
      .o_cpu_clk_en(cpu), .o_periph_clk_en(per), .o_osc_en(osc), .o_mc_tick(tick),
      .o_sfr_reset(sfr), .o_ale(ale_o), .o_program_fetch_strobe(pfs_o), .o_port_hold(hold));
   rpm_cpu_model u_cpu (.i_ref_clk(clk), .i_rst_n(rst_n), .i_cpu_clk_en(cpu),
      .i_mc_tick(tick), .i_reset_req(rreq), .o_instr_done(done), .o_ale(ale),
      .o_fetch(pfs), .o_ext_reset(xrst));
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      tests_run++;
      if (seen !== want) begin
         n_fail++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, want);
      end
   endtask
   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wd <= v;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] want);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      exp_q.push_back(want);
      @(posedge clk);
      rd_s <= 1'b0;
   endtask
   task automatic wcpu(input logic v);
      for (int i = 0; i < 2000 && cpu !== v; i++) @(posedge clk);
      check({7'h00, cpu}, {7'h00, v});
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      rd_d <= rd_s;
      if (rd_d) check(rdata, exp_q.pop_front());
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         conclude();
      end
   end
   initial begin
      void'($urandom(50650));
      d = 8'($urandom) & 8'hFC;
      pin = 8'h01 << ($urandom % 8);
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rd(rpm_pkg::PMC_ADDR, 8'h00);
      rd(8'h55, 8'h00);
      wr(rpm_pkg::PMC_ADDR, d | 8'h01);
      wcpu(1'b0);
      rd(rpm_pkg::STATUS_ADDR, 8'h01);
      repeat (2) @(posedge clk);
      ce <= 1'b0;
      irq <= 1'b1;
      repeat (4) @(posedge clk);
      check({7'h00, cpu}, 8'h00);
      check({5'h00, ale_o, pfs_o, hold}, 8'h07);
      ce <= 1'b1;
      wcpu(1'b1);
      irq <= 1'b0;
      rd(rpm_pkg::PMC_ADDR, d & 8'h0C);
      $display("Idle test done");
      wr(rpm_pkg::PMC_ADDR, 8'h03);
      wcpu(1'b0);
      rd(rpm_pkg::STATUS_ADDR, 8'h02);
      check({5'h00, ale_o, pfs_o, hold}, 8'h01);
      wk_en <= pin;
      wk_n <= ~pin;
      wcpu(1'b1);
      wk_n <= 8'hFF;
      $display("Power-down test done");
      wr(rpm_pkg::PMC_ADDR, d | 8'h01);
      wcpu(1'b0);
      rreq <= 1'b1;
      @(posedge clk);
      rreq <= 1'b0;
      wcpu(1'b1);
      check({7'h00, sfr}, 8'h01);
      rd(rpm_pkg::PMC_ADDR, 8'h00);
      rd(rpm_pkg::STATUS_ADDR, 8'h00);
      repeat (2) @(posedge clk);
      $display("Reset test done");
      conclude();
   end
endmodule
`default_nettype wire
